// [pkg/art_params.svh]
// Register offsets, field positions, reset values and timing constants of the auto-reload timer.
`ifndef ART_PARAMS_SVH
`define ART_PARAMS_SVH
`define ART_OFF_CSR 8'h00
`define ART_OFF_CNTH 8'h04
`define ART_OFF_CNTL 8'h08
`define ART_OFF_RLDH 8'h0C
`define ART_OFF_RLDL 8'h10
`define ART_OFF_PWMOE 8'h14
`define ART_OFF_CH0 8'h18
`define ART_OFF_CH1 8'h1C
`define ART_OFF_CH2 8'h20
`define ART_OFF_CH3 8'h24
`define ART_OFF_CTL2 8'h28
`define ART_OFF_CAPH 8'h2C
`define ART_OFF_CAPL 8'h30
`define ART_OFF_RLD2H 8'h34
`define ART_OFF_RLD2L 8'h38
`define ART_OFF_DUTY0 8'h3C
`define ART_CSR_CAPF 6
`define ART_CSR_CAPIE 5
`define ART_CSR_CKHI 4
`define ART_CSR_CKLO 3
`define ART_CSR_OVERFLOW_FLAG_ONE 2
`define ART_CSR_OVIE1 1
`define ART_CSR_COMPARE_IRQ_ENABLE 0
`define ART_CH_OPEN 3
`define ART_CH_ONE_PULSE_EDGE_SELECT 2
`define ART_CH_POL 1
`define ART_CH_CMPF 0
`define ART_CTL2_FORCE_OVERFLOW_TWO 7
`define ART_CTL2_FORCE_OVERFLOW_ONE 6
`define ART_CTL2_OVERFLOW_IRQ_ENABLE_TWO 4
`define ART_CTL2_OVERFLOW_FLAG_TWO 3
`define ART_CTL2_EN2 2
`define ART_CNT_MAX 12'hFFF
`define ART_CNT_ZERO 12'h000
`define ART_RESP_OKAY 2'b00
`define ART_RESP_SLVERR 2'b10
`define ART_CLK_MHZ 125
`define ART_FAST_MHZ 32
`endif

// [pkg/art_pkg.sv]
// Types shared by the auto-reload timer.
package art_pkg;
    typedef enum logic [1:0] {
        ART_CLK_OFF = 2'b00,
        ART_CLK_TICK = 2'b01,
        ART_CLK_CPU = 2'b10,
        ART_CLK_FAST = 2'b11
    } art_clksel_type;
endpackage

// [rtl/art_timer.sv]
// Auto-reload timer control, status, counters and compare with an AXI4-Lite slave.
//
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "art_params.svh"
module art_timer #(
    parameter int CNT_W = 12
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic haltMode,
    input wire logic globalIrqMask,
    input wire logic liteTimerTick,
    input wire logic captureInput,
    input wire logic lite_timer_trigger_input,
    output logic irqCaptureCompare,
    output logic irqOverflow,
    output logic [3:0] pwmOut,
    output logic [3:0] pwmOutEnable
);
    localparam int FAST_STEP = `ART_FAST_MHZ;
    localparam int FAST_MOD = `ART_CLK_MHZ;

    logic [1:0] haltSync, tickSync, capSync, trigSync;
    logic tickPrev, capPrev, trigPrev;
    logic [CNT_W-1:0] counter_one, counter_two, reload_value_one, reload_value_two;
    logic [CNT_W-1:0] capture_value;
    logic [CNT_W-1:0] channel_duty_value [4];
    logic [7:0] fastAcc;
    logic capture_flag, capture_irq_enable, overflow_flag_one, overflow_irq_enable_one;
    logic compare_irq_enable, overflow_flag_two, overflow_irq_enable_two, counterTwoEnable;
    logic force_overflow_one, force_overflow_two;
    art_pkg::art_clksel_type counter_clock_select;
    logic [3:0] pwm_output_enable_reg, channel_polarity, channel_compare_flag;
    logic one_pulse_enable, one_pulse_edge_select, onePulseHold;
    logic awHeld, wHeld;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;

    function automatic logic [7:0] hiByte(input logic [CNT_W-1:0] v);
        return {4'h0, v[CNT_W-1:8]};
    endfunction

    // Halt, tick, capture and trigger inputs pass two flip-flops before use.
    always_ff @(posedge clk) begin
        haltSync <= {haltSync[0], haltMode};
        tickSync <= {tickSync[0], liteTimerTick};
        capSync <= {capSync[0], captureInput};
        trigSync <= {trigSync[0], lite_timer_trigger_input};
        tickPrev <= tickSync[1];
        capPrev <= capSync[1];
        trigPrev <= trigSync[1];
    end

    wire logic running = !haltSync[1];
    wire logic fastStep = (fastAcc + 8'(FAST_STEP)) >= 8'(FAST_MOD);
    logic tick;
    always_comb begin
        unique case (counter_clock_select)
            art_pkg::ART_CLK_OFF: tick = 1'b0;
            art_pkg::ART_CLK_TICK: tick = tickSync[1] && !tickPrev;
            art_pkg::ART_CLK_CPU: tick = 1'b1;
            art_pkg::ART_CLK_FAST: tick = fastStep;
        endcase
    end

    // A fractional accumulator approximates the 32 MHz rate.
    always_ff @(posedge clk) begin
        if (rst) begin
            fastAcc <= 8'h00;
        end else if (fastStep) begin
            fastAcc <= 8'(fastAcc + 8'(FAST_STEP) - 8'(FAST_MOD));
        end else begin
            fastAcc <= 8'(fastAcc + 8'(FAST_STEP));
        end
    end

    wire logic step = running && tick;
    wire logic wrap1 = step && counter_one == `ART_CNT_MAX;
    wire logic wrap2 = step && counterTwoEnable && counter_two == `ART_CNT_MAX;
    wire logic trigEdge = one_pulse_edge_select ? (trigSync[1] && !trigPrev)
                                                : (!trigSync[1] && trigPrev);
    wire logic opRestart = one_pulse_enable && counterTwoEnable && running && trigEdge
                           && !onePulseHold;

    // Counter one with forced and natural overflow.
    always_ff @(posedge clk) begin
        if (rst) begin
            counter_one <= `ART_CNT_ZERO;
        end else if (force_overflow_one && running && counter_one != `ART_CNT_MAX) begin
            counter_one <= `ART_CNT_MAX;
        end else if (wrap1) begin
            counter_one <= reload_value_one;
        end else if (step) begin
            counter_one <= counter_one + 1'b1;
        end
    end

    // Counter two; one-pulse trigger restarts it from zero.
    always_ff @(posedge clk) begin
        if (rst) begin
            counter_two <= `ART_CNT_ZERO;
        end else if (opRestart) begin
            counter_two <= `ART_CNT_ZERO;
        end else if (force_overflow_two && running && counter_two != `ART_CNT_MAX) begin
            counter_two <= `ART_CNT_MAX;
        end else if (wrap2) begin
            counter_two <= reload_value_two;
        end else if (step && counterTwoEnable) begin
            counter_two <= counter_two + 1'b1;
        end
    end

    // Further triggers are ignored until counter two reaches channel three duty.
    always_ff @(posedge clk) begin
        if (rst || !one_pulse_enable) begin
            onePulseHold <= 1'b0;
        end else if (opRestart) begin
            onePulseHold <= 1'b1;
        end else if (counter_two == channel_duty_value[3]) begin
            onePulseHold <= 1'b0;
        end
    end

    wire logic awFire = s_axi_awvalid && s_axi_awready;
    wire logic wFire = s_axi_wvalid && s_axi_wready;
    wire logic doWrite = awHeld && wHeld && !s_axi_bvalid;
    wire logic doRead = s_axi_arvalid && s_axi_arready;
    wire logic readCsr = doRead && s_axi_araddr == `ART_OFF_CSR;
    wire logic readCap = doRead && (s_axi_araddr == `ART_OFF_CAPH || s_axi_araddr == `ART_OFF_CAPL);
    wire logic readCtl2 = doRead && s_axi_araddr == `ART_OFF_CTL2;
    wire logic wrCtl2 = doWrite && awAddr == `ART_OFF_CTL2 && wStrb[0];
    wire logic capEdge = capSync[1] && !capPrev && running;

    // Write address and data are taken in either order.
    always_ff @(posedge clk) begin
        if (rst) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddr <= 8'h00;
            wData <= 32'h0000_0000;
            wStrb <= 4'h0;
        end else begin
            if (awFire) begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end else if (doWrite) begin
                awHeld <= 1'b0;
            end
            if (wFire) begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end else if (doWrite) begin
                wHeld <= 1'b0;
            end
        end
    end

    // Ready flags are registered from the next held and response states.
    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_awready <= !(awFire || (awHeld && !doWrite))
                             && !(doWrite || (s_axi_bvalid && !s_axi_bready));
            s_axi_wready <= !(wFire || (wHeld && !doWrite))
                            && !(doWrite || (s_axi_bvalid && !s_axi_bready));
            s_axi_arready <= !(doRead || (s_axi_rvalid && !s_axi_rready));
        end
    end

    // Software-written control fields.
    always_ff @(posedge clk) begin
        if (rst) begin
            capture_irq_enable <= 1'b0;
            counter_clock_select <= art_pkg::ART_CLK_OFF;
            overflow_irq_enable_one <= 1'b0;
            compare_irq_enable <= 1'b0;
            reload_value_one <= `ART_CNT_ZERO;
            reload_value_two <= `ART_CNT_ZERO;
            pwm_output_enable_reg <= 4'h0;
            channel_polarity <= 4'h0;
            one_pulse_enable <= 1'b0;
            one_pulse_edge_select <= 1'b0;
            overflow_irq_enable_two <= 1'b0;
            counterTwoEnable <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                channel_duty_value[i] <= `ART_CNT_ZERO;
            end
        end else if (doWrite && wStrb[0]) begin
            unique case (awAddr)
                `ART_OFF_CSR: begin
                    capture_irq_enable <= wData[`ART_CSR_CAPIE];
                    counter_clock_select <= art_pkg::art_clksel_type'(
                        wData[`ART_CSR_CKHI:`ART_CSR_CKLO]);
                    overflow_irq_enable_one <= wData[`ART_CSR_OVIE1];
                    compare_irq_enable <= wData[`ART_CSR_COMPARE_IRQ_ENABLE];
                end
                `ART_OFF_RLDH: reload_value_one[CNT_W-1:8] <= wData[3:0];
                `ART_OFF_RLDL: reload_value_one[7:0] <= wData[7:0];
                `ART_OFF_RLD2H: reload_value_two[CNT_W-1:8] <= wData[3:0];
                `ART_OFF_RLD2L: reload_value_two[7:0] <= wData[7:0];
                `ART_OFF_PWMOE: pwm_output_enable_reg <= {wData[6], wData[4], wData[2], wData[0]};
                `ART_OFF_CH0: channel_polarity[0] <= wData[`ART_CH_POL];
                `ART_OFF_CH1: channel_polarity[1] <= wData[`ART_CH_POL];
                `ART_OFF_CH2: channel_polarity[2] <= wData[`ART_CH_POL];
                `ART_OFF_CH3: begin
                    channel_polarity[3] <= wData[`ART_CH_POL];
                    one_pulse_enable <= wData[`ART_CH_OPEN];
                    one_pulse_edge_select <= wData[`ART_CH_ONE_PULSE_EDGE_SELECT];
                end
                `ART_OFF_CTL2: begin
                    overflow_irq_enable_two <= wData[`ART_CTL2_OVERFLOW_IRQ_ENABLE_TWO];
                    counterTwoEnable <= wData[`ART_CTL2_EN2];
                end
                `ART_OFF_DUTY0: channel_duty_value[0] <= wData[CNT_W-1:0];
                `ART_OFF_DUTY0 + 8'h04: channel_duty_value[1] <= wData[CNT_W-1:0];
                `ART_OFF_DUTY0 + 8'h08: channel_duty_value[2] <= wData[CNT_W-1:0];
                `ART_OFF_DUTY0 + 8'h0C: channel_duty_value[3] <= wData[CNT_W-1:0];
                default: ;
            endcase
        end
    end

    // Force bits: software sets, hardware clears after the overflow.
    always_ff @(posedge clk) begin
        if (rst) begin
            force_overflow_one <= 1'b0;
            force_overflow_two <= 1'b0;
        end else begin
            if (wrCtl2 && wData[`ART_CTL2_FORCE_OVERFLOW_ONE]) begin
                force_overflow_one <= 1'b1;
            end else if (force_overflow_one && wrap1) begin
                force_overflow_one <= 1'b0;
            end
            if (wrCtl2 && wData[`ART_CTL2_FORCE_OVERFLOW_TWO]) begin
                force_overflow_two <= 1'b1;
            end else if (force_overflow_two && wrap2) begin
                force_overflow_two <= 1'b0;
            end
        end
    end

    // Status flags; an overflow set in the clearing cycle wins, a capture edge in the capture clearing cycle is lost.
    always_ff @(posedge clk) begin
        if (rst) begin
            overflow_flag_one <= 1'b0;
            overflow_flag_two <= 1'b0;
            capture_flag <= 1'b0;
            capture_value <= `ART_CNT_ZERO;
        end else begin
            if (wrap1) begin
                overflow_flag_one <= 1'b1;
            end else if (readCsr) begin
                overflow_flag_one <= 1'b0;
            end
            if (wrap2 || opRestart) begin
                overflow_flag_two <= 1'b1;
            end else if (readCtl2) begin
                overflow_flag_two <= 1'b0;
            end
            if (capEdge && !capture_flag) begin
                capture_flag <= 1'b1;
                capture_value <= counter_one;
            end else if (readCap) begin
                capture_flag <= 1'b0;
            end
        end
    end

    // Compare flags and PWM outputs; channels two and three follow counter two when enabled.
    always_ff @(posedge clk) begin
        if (rst) begin
            channel_compare_flag <= 4'h0;
            pwmOut <= 4'h0;
            pwmOutEnable <= 4'h0;
        end else begin
            pwmOutEnable <= pwm_output_enable_reg;
            for (int i = 0; i < 4; i++) begin
                logic [CNT_W-1:0] cnt;
                logic useTwo;
                useTwo = counterTwoEnable && i >= 2;
                cnt = useTwo ? counter_two : counter_one;
                if (cnt == channel_duty_value[i] && running) begin
                    channel_compare_flag[i] <= 1'b1;
                end else if (doRead && s_axi_araddr == `ART_OFF_CH0 + 8'(4 * i)) begin
                    channel_compare_flag[i] <= 1'b0;
                end
                pwmOut[i] <= pwm_output_enable_reg[i] &&
                             ((cnt >= channel_duty_value[i]) ^ channel_polarity[i]);
            end
        end
    end

    // Interrupt requests behind the enables and the global mask.
    always_ff @(posedge clk) begin
        if (rst) begin
            irqCaptureCompare <= 1'b0;
            irqOverflow <= 1'b0;
        end else begin
            irqCaptureCompare <= !globalIrqMask && ((capture_flag && capture_irq_enable)
                || (|channel_compare_flag && compare_irq_enable));
            irqOverflow <= !globalIrqMask && ((overflow_flag_one && overflow_irq_enable_one)
                || (overflow_flag_two && overflow_irq_enable_two));
        end
    end

    // Write response and read data.
    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ART_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `ART_RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
        end else begin
            if (doWrite) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awAddr <= `ART_OFF_DUTY0 + 8'h0C && awAddr[1:0] == 2'b00)
                               ? `ART_RESP_OKAY : `ART_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (doRead) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `ART_RESP_OKAY;
                unique case (s_axi_araddr)
                    `ART_OFF_CSR: s_axi_rdata <= {25'h0, capture_flag, capture_irq_enable,
                        counter_clock_select, overflow_flag_one, overflow_irq_enable_one,
                        compare_irq_enable};
                    `ART_OFF_CNTH: s_axi_rdata <= {24'h0, hiByte(counter_one)};
                    `ART_OFF_CNTL: s_axi_rdata <= {24'h0, counter_one[7:0]};
                    `ART_OFF_RLDH: s_axi_rdata <= {24'h0, hiByte(reload_value_one)};
                    `ART_OFF_RLDL: s_axi_rdata <= {24'h0, reload_value_one[7:0]};
                    `ART_OFF_PWMOE: s_axi_rdata <= {25'h0, pwm_output_enable_reg[3], 1'b0,
                        pwm_output_enable_reg[2], 1'b0, pwm_output_enable_reg[1], 1'b0,
                        pwm_output_enable_reg[0]};
                    `ART_OFF_CH0, `ART_OFF_CH1, `ART_OFF_CH2: s_axi_rdata <= {30'h0,
                        channel_polarity[s_axi_araddr[3:2] - 2'd2],
                        channel_compare_flag[s_axi_araddr[3:2] - 2'd2]};
                    `ART_OFF_CH3: s_axi_rdata <= {28'h0, one_pulse_enable,
                        one_pulse_edge_select, channel_polarity[3],
                        channel_compare_flag[3]};
                    `ART_OFF_CTL2: s_axi_rdata <= {24'h0, force_overflow_two,
                        force_overflow_one, 1'b0, overflow_irq_enable_two,
                        overflow_flag_two, counterTwoEnable, 2'b00};
                    `ART_OFF_CAPH: s_axi_rdata <= {24'h0, hiByte(capture_value)};
                    `ART_OFF_CAPL: s_axi_rdata <= {24'h0, capture_value[7:0]};
                    `ART_OFF_RLD2H: s_axi_rdata <= {24'h0, hiByte(reload_value_two)};
                    `ART_OFF_RLD2L: s_axi_rdata <= {24'h0, reload_value_two[7:0]};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= (s_axi_araddr >= `ART_OFF_DUTY0
                            && s_axi_araddr <= `ART_OFF_DUTY0 + 8'h0C)
                            ? `ART_RESP_OKAY : `ART_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    force_clear_a: assert property (@(posedge clk) disable iff (rst)
        force_overflow_one && wrap1 && !wrCtl2 |=> !force_overflow_one)
        else $error("Force bit one not cleared after overflow.");
    reload_load_a: assert property (@(posedge clk) disable iff (rst)
        wrap1 && !force_overflow_one |=> counter_one == $past(reload_value_one))
        else $error("Counter one not reloaded on overflow.");
    force_load_a: assert property (@(posedge clk) disable iff (rst)
        force_overflow_one && running && counter_one != `ART_CNT_MAX
        |=> counter_one == `ART_CNT_MAX)
        else $error("Force did not load the maximum value.");
    halt_stop_a: assert property (@(posedge clk) disable iff (rst)
        haltSync[1] && !force_overflow_one |=> $stable(counter_one))
        else $error("Counter moved while halted.");
    ovf_flag_a: assert property (@(posedge clk) disable iff (rst)
        wrap1 |=> overflow_flag_one)
        else $error("Overflow flag one not set.");
    off_clock_a: assert property (@(posedge clk) disable iff (rst)
        counter_clock_select == art_pkg::ART_CLK_OFF && !force_overflow_one
        |=> $stable(counter_one))
        else $error("Counter moved with clock off.");
    irq_mask_a: assert property (@(posedge clk) disable iff (rst)
        globalIrqMask |=> !irqOverflow && !irqCaptureCompare)
        else $error("Interrupt raised while masked.");
    cap_hold_a: assert property (@(posedge clk) disable iff (rst)
        capture_flag && !readCap |=> capture_flag && $stable(capture_value))
        else $error("Capture flag or value lost.");
    cmp_flag_a: assert property (@(posedge clk) disable iff (rst)
        running && counter_one == channel_duty_value[0] |=> channel_compare_flag[0])
        else $error("Compare flag zero not set on match.");
endmodule
`default_nettype wire

// [test/tb_autoreload_timer_ctrl_force.sv]
// Self-checking testbench of the auto-reload timer control and status logic.
`timescale 1ns/1ps
`default_nettype none
`include "art_params.svh"
module tb_autoreload_timer_ctrl_force;
    logic clk = 0;
    logic rst = 1;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rd;
    logic [3:0] wstrb = 0, pwmOut, pwmOutEnable;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, irqCc, irqOv;
    logic [1:0] bresp, rresp, rsp;
    logic haltMode = 0, globalIrqMask = 0, tick = 0, capIn = 0, trig = 0;
    logic [11:0] rld, cnt;
    logic [7:0] offs [6] = '{`ART_OFF_CSR, `ART_OFF_CNTH, `ART_OFF_CNTL,
        `ART_OFF_RLDH, `ART_OFF_RLDL, `ART_OFF_PWMOE};
    int fails = 0, checked = 0, cycles = 0, n;
    art_timer dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .haltMode(haltMode), .globalIrqMask(globalIrqMask), .liteTimerTick(tick),
        .captureInput(capIn), .lite_timer_trigger_input(trig),
        .irqCaptureCompare(irqCc), .irqOverflow(irqOv), .pwmOut(pwmOut),
        .pwmOutEnable(pwmOutEnable));
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        checked++;
        if (seen !== expv) begin
            fails++;
            $display("Error at %0t: saw %h expected %h", $time, seen, expv);
        end
    endtask
    task automatic test_done();
        if (fails == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, ha, hw;
        ta = 0;
        tw = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ta && tw)) begin
            @(negedge clk);
            ha = awvalid && awready;
            hw = wvalid && wready;
            @(posedge clk);
            if (ha) begin
                awvalid <= 1'b0;
                ta = 1;
            end
            if (hw) begin
                wvalid <= 1'b0;
                tw = 1;
            end
        end
        do @(negedge clk); while (!bvalid);
        @(posedge clk);
        bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge clk); while (!arready);
        @(posedge clk);
        arvalid <= 1'b0;
        do @(negedge clk); while (!rvalid);
        d = rdata;
        r = rresp;
        @(posedge clk);
        rready <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        axr(a, rd, rsp);
        check(rd, e);
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            test_done();
        end
    end
    initial begin
        rld = 12'($urandom(32'h0000_58be));
        rld = 12'($urandom_range(2047, 16));
        n = $urandom_range(8, 1);
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 6; i++) begin
            rc(offs[i], 32'h0000_0000);
        end
        axr(8'hFC, rd, rsp);
        check({30'h0000_0000, rsp}, {30'h0000_0000, `ART_RESP_SLVERR});
        axw(`ART_OFF_RLDL, {24'h00_0000, rld[7:0]});
        axw(`ART_OFF_RLDH, {24'h00_0000, 4'hF, rld[11:8]});
        rc(`ART_OFF_RLDL, {24'h00_0000, rld[7:0]});
        rc(`ART_OFF_RLDH, {28'h000_0000, rld[11:8]});
        axw(`ART_OFF_PWMOE, 32'h0000_00FF);
        rc(`ART_OFF_PWMOE, 32'h0000_0055);
        check({28'h000_0000, pwmOutEnable}, 32'h0000_000F);
        axw(`ART_OFF_DUTY0, {20'h0_0000, rld});
        axr(`ART_OFF_CH0, rd, rsp);
        axw(`ART_OFF_CSR, 32'h0000_0003);
        axw(`ART_OFF_CTL2, 32'h0000_0040);
        rc(`ART_OFF_CNTL, 32'h0000_00FF);
        rc(`ART_OFF_CNTH, 32'h0000_000F);
        axr(`ART_OFF_CTL2, rd, rsp);
        check(rd & 32'h0000_00C0, 32'h0000_0040);
        haltMode <= 1'b1;
        axw(`ART_OFF_CSR, 32'h0000_0013);
        repeat (8) @(posedge clk);
        rc(`ART_OFF_CNTL, 32'h0000_00FF);
        haltMode <= 1'b0;
        repeat (8) @(posedge clk);
        check({31'h0000_0000, irqOv}, 32'h0000_0001);
        globalIrqMask <= 1'b1;
        repeat (2) @(posedge clk);
        check({31'h0000_0000, irqOv}, 32'h0000_0000);
        globalIrqMask <= 1'b0;
        axw(`ART_OFF_CSR, 32'h0000_0003);
        axr(`ART_OFF_CNTL, rd, rsp);
        cnt[7:0] = rd[7:0];
        axr(`ART_OFF_CNTH, rd, rsp);
        cnt[11:8] = rd[3:0];
        check({31'h0000_0000, cnt > rld && cnt < rld + 12'd200}, 32'h0000_0001);
        axr(`ART_OFF_CTL2, rd, rsp);
        check(rd & 32'h0000_00C0, 32'h0000_0000);
        rc(`ART_OFF_CSR, 32'h0000_0007);
        rc(`ART_OFF_CSR, 32'h0000_0003);
        for (int i = 1; i < 4; i++) begin
            rc(`ART_OFF_CH0 + 8'(4 * i), 32'h0000_0001);
        end
        check({31'h0000_0000, irqCc}, 32'h0000_0001);
        rc(`ART_OFF_CH0, 32'h0000_0001);
        rc(`ART_OFF_CH0, 32'h0000_0000);
        repeat (2) @(posedge clk);
        check({31'h0000_0000, irqCc}, 32'h0000_0000);
        axw(`ART_OFF_CSR, 32'h0000_000B);
        repeat (n) begin
            tick <= 1'b1;
            repeat (4) @(posedge clk);
            tick <= 1'b0;
            repeat (4) @(posedge clk);
        end
        axw(`ART_OFF_CSR, 32'h0000_0023);
        cnt = cnt + 12'(n);
        rc(`ART_OFF_CNTL, {24'h00_0000, cnt[7:0]});
        capIn <= 1'b1;
        repeat (4) @(posedge clk);
        capIn <= 1'b0;
        repeat (4) @(posedge clk);
        check({31'h0000_0000, irqCc}, 32'h0000_0001);
        axw(`ART_OFF_CSR, 32'h0000_0003);
        rc(`ART_OFF_CSR, 32'h0000_0043);
        check({31'h0000_0000, irqCc}, 32'h0000_0000);
        rc(`ART_OFF_CAPL, {24'h00_0000, cnt[7:0]});
        rc(`ART_OFF_CSR, 32'h0000_0003);
        axw(`ART_OFF_CH1, 32'h0000_0002);
        axw(`ART_OFF_CTL2, 32'h0000_0004);
        axw(`ART_OFF_CH3, 32'h0000_000C);
        trig <= 1'b1;
        repeat (4) @(posedge clk);
        rc(`ART_OFF_CTL2, 32'h0000_000C);
        trig <= 1'b0;
        repeat (4) @(posedge clk);
        rc(`ART_OFF_CTL2, 32'h0000_0004);
        check({28'h000_0000, pwmOut}, 32'h0000_000D);
        rc(`ART_OFF_CH3, 32'h0000_000D);
        test_done();
    end
endmodule
`default_nettype wire
